// ==== aoc_alu.sv ====
// atomic arithmetic: fetch-add, swap and compare-swap on a size-masked operand.
// assumes operands arrive zero-extended in the low bits.
module aoc_alu
   import aoc_pkg::*;
(
   input wire logic [1:0] op,
   input wire logic [1:0] size,
   input wire logic [127:0] orig,
   input wire logic [127:0] opa,
   input wire logic [127:0] opb,
   output logic [127:0] result,
   output logic write_back
);
   function automatic logic [127:0] size_mask(input logic [1:0] sz);
      unique case (sz)
         2'h0: size_mask = {96'h0, {32{1'b1}}};
         2'h1: size_mask = {64'h0, {64{1'b1}}};
         default: size_mask = {128{1'b1}};
      endcase
   endfunction

   always_comb begin
      logic [127:0] m;
      m = size_mask(size);
      result = '0;
      write_back = 1'b0;
      unique case (op)
         AOC_OP_FADD: begin
            result = (orig + opa) & m;
            write_back = 1'b1;
         end
         AOC_OP_SWAP: begin
            result = opa & m;
            write_back = 1'b1;
         end
         default: begin
            result = opb & m;
            write_back = ((orig & m) == (opa & m));
         end
      endcase
   end
endmodule

// ==== aoc_axil.sv ====
// axi4-lite register slave: one write and one read at a time; reads answer in one cycle, writes one cycle after address and data are both held.
// assumes a single master; unmapped reads return zero with slverr.
module aoc_axil
   import aoc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_hit,
   input wire logic wr_hit
);
   logic aw_have_r, w_have_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   assign s_awready = !aw_have_r && !s_bvalid;
   assign s_wready = !w_have_r && !s_bvalid;
   assign wr_en = aw_have_r && w_have_r && !s_bvalid;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;
   assign s_arready = !s_rvalid;
   assign rd_addr = s_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_wdata;
            wstrb_r <= s_wstrb;
         end
         if (wr_en) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= 2'h0;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_hit ? rd_data : 32'h0;
         s_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule

// ==== aoc_mem_model.sv ====
// memory model behind the completer's local port: reads answer after LAT cycles.
// assumes one read outstanding at a time, as the completer issues them.
module aoc_mem_model
   import aoc_pkg::*;
#(parameter int LAT = 3)
(
   input wire logic aclk,
   input wire logic mem_valid,
   input wire aoc_pkg::aoc_mem_s mem,
   input wire logic err_en,
   output logic mem_rvalid,
   output logic [127:0] mem_rdata,
   output logic mem_err
);
   logic [127:0] store_r [4] = '{default: '0};
   logic [127:0] msk;
   logic [1:0] idx_r = 2'h0;
   int cnt_r = 0;
   assign msk = (mem.size == 2'h0) ? {96'h0, 32'hffff_ffff} : (mem.size == 2'h1) ? {64'h0, {64{1'b1}}} : '1;
   always_ff @(posedge aclk) begin
      mem_rvalid <= 1'b0;
      mem_err <= 1'b0;
      // outside a valid beat the data lines show garbage, never the last value
      mem_rdata <= ~store_r[idx_r];
      if (mem_valid && mem.we)
         store_r[mem.addr[5:4]] <= (store_r[mem.addr[5:4]] & ~msk) | (mem.wdata & msk);
      if (mem_valid && !mem.we) begin
         cnt_r <= LAT;
         idx_r <= mem.addr[5:4];
      end else if (cnt_r > 0)
         cnt_r <= cnt_r - 1;
      if (cnt_r == 1) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= store_r[idx_r];
         mem_err <= err_en;
      end
   end
endmodule

// ==== aoc_pkg.sv ====
// package for the atomic operation completer: request/answer carriers, codes,
// register map and field positions.
// assumes a transaction layer that delivers decoded request headers one at a time.
package aoc_pkg;
   // request type codes
   localparam logic [1:0] AOC_OP_FADD = 2'h0;
   localparam logic [1:0] AOC_OP_SWAP = 2'h1;
   localparam logic [1:0] AOC_OP_CAS = 2'h2;
   // completion status codes
   localparam logic [2:0] AOC_ST_SC = 3'h0;
   localparam logic [2:0] AOC_ST_UR = 3'h1;
   localparam logic [2:0] AOC_ST_CA = 3'h4;
   // register byte offsets
   localparam logic [7:0] AOC_REG_CAP = 8'h00;
   localparam logic [7:0] AOC_REG_CTRL = 8'h04;
   localparam logic [7:0] AOC_REG_ERR = 8'h08;
   localparam logic [7:0] AOC_REG_WIN_LO = 8'h0c;
   localparam logic [7:0] AOC_REG_WIN_HI = 8'h10;
   localparam logic [7:0] AOC_REG_SEV = 8'h14;
   // capability bits
   localparam int AOC_CAP_ROUTE = 6;
   localparam int AOC_CAP_32 = 7;
   localparam int AOC_CAP_64 = 8;
   localparam int AOC_CAP_128 = 9;
   // control bits
   localparam int AOC_CTRL_EGB = 7;
   localparam int AOC_CTRL_PEER = 8;
   // error status bits (write one to clear)
   localparam int AOC_ERR_POISON = 0;
   localparam int AOC_ERR_UR = 1;
   localparam int AOC_ERR_MAL = 2;
   localparam int AOC_ERR_CA = 3;
   localparam int AOC_ERR_EGB = 4;
   localparam int AOC_ERR_ADV = 5;
   localparam int AOC_ERR_PEER = 6;
   localparam logic [31:0] AOC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] AOC_WIN_LO_RST = 32'h0000_0000;
   localparam logic [31:0] AOC_WIN_HI_RST = 32'hffff_ffff;
   localparam logic AOC_SUP_128 = 1'b1;

   typedef struct packed {
      logic [1:0] op;
      logic [3:0] length;
      logic addr64;
      logic [63:0] addr;
      logic poisoned;
      logic no_snoop;
      logic relaxed;
      logic egress_out;
      logic peer_route;
      logic acs_fail;
      logic [127:0] opa;
      logic [127:0] opb;
      logic [15:0] tag;
   } aoc_req_s;

   typedef struct packed {
      logic [2:0] status;
      logic relaxed;
      logic [15:0] tag;
      logic [1:0] size;
      logic [127:0] data;
   } aoc_cpl_s;

   typedef struct packed {
      logic we;
      logic [63:0] addr;
      logic [127:0] wdata;
      logic [1:0] size;
   } aoc_mem_s;
endpackage

// ==== aoc_top.sv ====
// atomic operation completer and egress gate: decodes one atomic request,
// classifies errors, performs the read-modify-write on a local memory port, answers.
// assumes memory port reads return in mem_rvalid and writes complete on the cycle issued;
// the request source holds req_valid until req_ready.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module aoc_top
   import aoc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_valid,
   output logic req_ready,
   input wire aoc_pkg::aoc_req_s req,
   output logic cpl_valid,
   input wire logic cpl_ready,
   output aoc_pkg::aoc_cpl_s cpl,
   output logic mem_valid,
   output aoc_pkg::aoc_mem_s mem,
   input wire logic mem_rvalid,
   input wire logic [127:0] mem_rdata,
   input wire logic mem_err,
   output logic ur_detected,
   output logic lock_active,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   import aoc_pkg::*;

   typedef enum logic [4:0] {
      AOC_IDLE = 5'b00001,
      AOC_READ = 5'b00010,
      AOC_WAIT = 5'b00100,
      AOC_WRITE = 5'b01000,
      AOC_CPL = 5'b10000
   } aoc_state_e;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // length is in dwords; fetch-add/swap carry one operand, compare-swap two
   function automatic logic len_legal(input logic [1:0] op, input logic [3:0] len);
      if (op == AOC_OP_CAS)
         len_legal = (len == 4'h2) || (len == 4'h4) || (len == 4'h8);
      else
         len_legal = (len == 4'h1) || (len == 4'h2);
   endfunction

   function automatic logic [1:0] len_size(input logic [1:0] op, input logic [3:0] len);
      logic [3:0] per;
      per = (op == AOC_OP_CAS) ? {1'b0, len[3:1]} : len;
      len_size = (per == 4'h1) ? 2'h0 : (per == 4'h2) ? 2'h1 : 2'h2;
   endfunction

   // the memory port hands back a whole line; answers must carry only the operand,
   // otherwise stale upper bits of a wider earlier access leak into a narrow answer
   function automatic logic [127:0] size_mask(input logic [1:0] sz);
      unique case (sz)
         2'h0: size_mask = {96'h0, {32{1'b1}}};
         2'h1: size_mask = {64'h0, {64{1'b1}}};
         default: size_mask = {128{1'b1}};
      endcase
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic wr_en, rd_hit, wr_hit;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data, cap_val;
   logic [3:0] wr_strb;
   logic [31:0] ctrl_r, win_lo_r, win_hi_r, sev_r;
   logic [6:0] err_r, err_set;

   assign cap_val = (32'h1 << AOC_CAP_ROUTE) | (32'h1 << AOC_CAP_32) | (32'h1 << AOC_CAP_64)
                    | ({31'h0, AOC_SUP_128} << AOC_CAP_128);

   aoc_axil u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_hit(rd_hit),
      .wr_hit(wr_hit)
   );

   assign wr_hit = (wr_addr == AOC_REG_CAP) || (wr_addr == AOC_REG_CTRL) || (wr_addr == AOC_REG_ERR)
                   || (wr_addr == AOC_REG_WIN_LO) || (wr_addr == AOC_REG_WIN_HI) || (wr_addr == AOC_REG_SEV);

   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_addr)
         AOC_REG_CAP: rd_data = cap_val;
         AOC_REG_CTRL: rd_data = ctrl_r;
         AOC_REG_ERR: rd_data = {25'h0, err_r};
         AOC_REG_WIN_LO: rd_data = win_lo_r;
         AOC_REG_WIN_HI: rd_data = win_hi_r;
         AOC_REG_SEV: rd_data = sev_r;
         default: begin
            rd_data = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         if (s[i])
            old[i*8 +: 8] = d[i*8 +: 8];
      merge = old;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= AOC_CTRL_RST;
         win_lo_r <= AOC_WIN_LO_RST;
         win_hi_r <= AOC_WIN_HI_RST;
         sev_r <= 32'h0;
      end else if (wr_en) begin
         // only the egress-block and peer bits are writable in control
         if (wr_addr == AOC_REG_CTRL)
            ctrl_r <= merge(ctrl_r, wr_data, wr_strb) & ((32'h1 << AOC_CTRL_EGB) | (32'h1 << AOC_CTRL_PEER));
         if (wr_addr == AOC_REG_WIN_LO)
            win_lo_r <= merge(win_lo_r, wr_data, wr_strb);
         if (wr_addr == AOC_REG_WIN_HI)
            win_hi_r <= merge(win_hi_r, wr_data, wr_strb);
         if (wr_addr == AOC_REG_SEV)
            sev_r <= merge(sev_r, wr_data, wr_strb) & (32'h1 << AOC_ERR_EGB);
      end
   end

   // set wins over the write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn)
         err_r <= 7'h00;
      else if (wr_en && wr_addr == AOC_REG_ERR && wr_strb[0])
         err_r <= (err_r & ~wr_data[6:0]) | err_set;
      else
         err_r <= err_r | err_set;
   end

   // ----------------------------------------------------------------
   // request classification
   // ----------------------------------------------------------------
   aoc_state_e state_r;
   aoc_req_s req_r;
   logic [1:0] size_r;
   logic [127:0] orig_r, alu_res;
   logic alu_wb;
   logic [127:0] orig_m;
   logic take, malformed, blocked, in_win, supported;
   logic [2:0] early_st;

   assign req_ready = (state_r == AOC_IDLE);
   assign take = req_valid && req_ready;
   // an unknown type with a legal length is well formed: it is refused, never dropped
   assign malformed = !len_legal(req.op, req.length);
   assign blocked = req.egress_out && ctrl_r[AOC_CTRL_EGB];
   assign supported = (req.op != 2'h3) && ((len_size(req.op, req.length) != 2'h2) || AOC_SUP_128);
   assign in_win = (req.addr >= {32'h0, win_lo_r}) && (req.addr <= {32'h0, win_hi_r});

   always_comb begin
      err_set = 7'h00;
      early_st = AOC_ST_SC;
      if (take) begin
         if (malformed)
            err_set[AOC_ERR_MAL] = 1'b1;
         else if (req.acs_fail) begin
            early_st = AOC_ST_CA;
            err_set[AOC_ERR_CA] = 1'b1;
         end else if (blocked) begin
            early_st = AOC_ST_UR;
            err_set[AOC_ERR_EGB] = 1'b1;
            err_set[AOC_ERR_ADV] = !sev_r[AOC_ERR_EGB];
         end else if (req.peer_route && !ctrl_r[AOC_CTRL_PEER]) begin
            early_st = AOC_ST_UR;
            err_set[AOC_ERR_PEER] = 1'b1;
            err_set[AOC_ERR_UR] = 1'b1;
         end else if (req.poisoned) begin
            early_st = AOC_ST_UR;
            err_set[AOC_ERR_POISON] = 1'b1;
         end else if (!supported) begin
            early_st = AOC_ST_UR;
            err_set[AOC_ERR_UR] = 1'b1;
         end else if (!in_win) begin
            early_st = AOC_ST_CA;
            err_set[AOC_ERR_CA] = 1'b1;
         end
      end
      if (state_r == AOC_WAIT && mem_rvalid && mem_err)
         err_set[AOC_ERR_CA] = 1'b1;
   end

   // unsupported-detected follows the ur bit only; egress-blocked never touches it
   assign ur_detected = err_r[AOC_ERR_UR];

   // ----------------------------------------------------------------
   // read-modify-write sequencer
   // ----------------------------------------------------------------
   aoc_alu u_alu (
      .op(req_r.op),
      .size(size_r),
      .orig(orig_r),
      .opa(req_r.opa),
      .opb(req_r.opb),
      .result(alu_res),
      .write_back(alu_wb)
   );

   assign orig_m = orig_r & size_mask(size_r);

   // the target stays locked from read issue to write, so no other access
   // interleaves; no-snoop is ignored on purpose
   assign lock_active = (state_r == AOC_READ) || (state_r == AOC_WAIT) || (state_r == AOC_WRITE);
   assign mem_valid = (state_r == AOC_READ) || (state_r == AOC_WRITE && alu_wb);
   assign mem.we = (state_r == AOC_WRITE);
   assign mem.addr = req_r.addr;
   assign mem.wdata = alu_res;
   assign mem.size = size_r;
   assign cpl_valid = (state_r == AOC_CPL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= AOC_IDLE;
         req_r <= '0;
         size_r <= 2'h0;
         orig_r <= '0;
         cpl <= '0;
      end else begin
         unique case (state_r)
            AOC_IDLE: if (take) begin
               req_r <= req;
               size_r <= len_size(req.op, req.length);
               cpl.tag <= req.tag;
               cpl.relaxed <= req.relaxed;
               cpl.size <= len_size(req.op, req.length);
               cpl.data <= '0;
               cpl.status <= early_st;
               // malformed packets are dropped with no completion
               if (malformed)
                  state_r <= AOC_IDLE;
               else if (early_st != AOC_ST_SC)
                  state_r <= AOC_CPL;
               else
                  state_r <= AOC_READ;
            end
            AOC_READ: state_r <= AOC_WAIT;
            AOC_WAIT: if (mem_rvalid) begin
               orig_r <= mem_rdata;
               if (mem_err) begin
                  cpl.status <= AOC_ST_CA;
                  state_r <= AOC_CPL;
               end else begin
                  state_r <= AOC_WRITE;
               end
            end
            AOC_WRITE: begin
               cpl.data <= orig_m;
               state_r <= AOC_CPL;
            end
            AOC_CPL: if (cpl_ready)
               state_r <= AOC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_poison_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed && early_st == AOC_ST_UR && req.poisoned |-> ##1 (!mem_valid)[*2])
      else $error("poisoned request touched memory");
   a_blocked_ur_status: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed && !req.acs_fail && blocked |-> ##1 cpl_valid && cpl.status == AOC_ST_UR)
      else $error("egress block did not answer unsupported");
   a_blocked_keeps_ur: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed && !req.acs_fail && blocked |-> ##1 $stable(ur_detected))
      else $error("egress block changed unsupported detected");
   a_mal_no_cpl: assert property (@(posedge aclk) disable iff (!aresetn)
      take && malformed |-> ##1 !cpl_valid && err_r[AOC_ERR_MAL])
      else $error("malformed request answered");
   a_err_abort_sts: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_WAIT && mem_rvalid && mem_err |-> ##1 cpl_valid && cpl.status == AOC_ST_CA)
      else $error("memory error did not abort");
   a_cas_miss_nowr: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_WRITE && req_r.op == AOC_OP_CAS && !alu_wb |-> !mem_valid ##1 cpl.data == $past(orig_m))
      else $error("compare miss wrote or lost original");
   a_fadd_sum_out: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_WRITE && req_r.op == AOC_OP_FADD && size_r == 2'h0 |->
      mem_valid && mem.wdata[31:0] == orig_r[31:0] + req_r.opa[31:0])
      else $error("fetch add sum wrong");
   a_relaxed_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed |-> ##1 cpl.relaxed == $past(req.relaxed))
      else $error("relaxed ordering not carried");
   a_egb_reset_clr: assert property (@(posedge aclk)
      !aresetn |-> ##1 !ctrl_r[AOC_CTRL_EGB])
      else $error("egress block not cleared by reset");
   a_lock_span: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_READ |-> lock_active ##1 lock_active)
      else $error("lock dropped during access");
   a_bad_op_ur: assert property (@(posedge aclk) disable iff (!aresetn)
      take && req.op == 2'h3 && !malformed && !req.acs_fail |-> ##1 cpl_valid && cpl.status == AOC_ST_UR)
      else $error("unknown type not refused as unsupported");
   a_acs_abort: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed && req.acs_fail |-> ##1 cpl_valid && cpl.status == AOC_ST_CA)
      else $error("access control failure not aborted");
   a_peer_ur_log: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !malformed && !req.acs_fail && !blocked && req.peer_route && !ctrl_r[AOC_CTRL_PEER] |->
      ##1 cpl.status == AOC_ST_UR && err_r[AOC_ERR_PEER])
      else $error("unsupported peer route not refused");
   a_size_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_READ |-> (req_r.length == 4'h1 && size_r == 2'h0)
      || (req_r.length == 4'h2 && size_r == ((req_r.op == AOC_OP_CAS) ? 2'h0 : 2'h1))
      || (req_r.length == 4'h4 && size_r == 2'h1) || (req_r.length == 4'h8 && size_r == 2'h2))
      else $error("operand size decoded wrongly");
   a_rsp_sized: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r == AOC_CPL && size_r != 2'h2 |->
      cpl.data[127:64] == 64'h0 && (size_r == 2'h1 || cpl.data[63:32] == 32'h0))
      else $error("answer wider than operand");
endmodule

// ==== atomic_op_completer_router_tb.sv ====
// bench for the atomic completer: register bus, request port and memory model.
// assumes the memory model answers reads after three cycles.
module atomic_op_completer_router_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import aoc_pkg::*;
   logic aclk, aresetn = 1'b0, req_valid = 1'b0, req_ready, cpl_valid, cpl_ready = 1'b1, err_en = 1'b0;
   logic mem_valid, mem_rvalid, mem_err, ur_detected, lock_active, s_awready, s_wready, s_bvalid;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic s_arready, s_rvalid;
   logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, rv;
   logic [3:0] s_wstrb = 4'hf;
   logic [1:0] s_bresp, s_rresp, rr;
   logic [127:0] mem_rdata;
   aoc_req_s req = '0;
   aoc_cpl_s cpl;
   aoc_mem_s mem;
   int mismatches = 0, checks = 0;
   aoc_top i_aoc_top (.*);
   aoc_mem_model i_aoc_mem_model (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ---------------------------------------------
   // bus and check helpers
   // ---------------------------------------------
   task automatic ck(input string nm, input logic [127:0] e, s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic to();
      mismatches++;
      $display("MISMATCH wait expected answer seen none");
      end_sim();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      {s_awvalid, s_wvalid, s_bready} <= 3'h7;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      s_bready <= 1'b0;
      if (n == 40) to();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_araddr <= a;
      {s_arvalid, s_rready} <= 2'h3;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
      if (n == 40) to();
   endtask
   // status 7 stands for no completion at all
   task automatic rq(input logic [1:0] op, input logic [3:0] ln, input logic [127:0] a, b,
      input logic [3:0] f, input logic [2:0] es, input logic [127:0] ed);
      int n;
      @(posedge aclk);
      req <= '{op, ln, 1'b1, 64'h20, f[0], 1'b1, ln[0], f[1], f[2], f[3], a, b, 16'h5a};
      req_valid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (req_ready) req_valid <= 1'b0;
         if (cpl_valid) break;
      end
      ck("status", es, (n < 40) ? cpl.status : 3'h7);
      if (es == AOC_ST_SC) ck("data", ed, cpl.data);
      if (n < 40) ck("relaxed", ln[0], cpl.relaxed);
      if (n < 40) ck("tag", 16'h5a, cpl.tag);
      if (n == 40 && es != 3'h7) to();
   endtask
   task automatic eb(input int b);
      rd(AOC_REG_ERR, rv, rr);
      ck("err", 1'b1, rv[b]);
      wr(AOC_REG_ERR, 32'hffff_ffff);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs();
      rd(AOC_REG_CAP, rv, rr);
      ck("cap", 3'h7, rv[9:7]);
      rd(AOC_REG_CTRL, rv, rr);
      ck("ctrl", 32'h0, rv);
      rd(8'h40, rv, rr);
      ck("resp", 2'h2, rr);
      $display("test regs done");
   endtask
   task automatic t_ops();
      rq(AOC_OP_SWAP, 4'h1, 128'hffff_fffe, '0, '0, AOC_ST_SC, '0);
      rq(AOC_OP_FADD, 4'h1, 128'h3, '0, '0, AOC_ST_SC, 128'hffff_fffe);
      rq(AOC_OP_SWAP, 4'h1, '0, '0, '0, AOC_ST_SC, 128'h1);
      rq(AOC_OP_FADD, 4'h2, {64'h0, {64{1'b1}}}, '0, '0, AOC_ST_SC, '0);
      rq(AOC_OP_SWAP, 4'h2, 128'h5, '0, '0, AOC_ST_SC, {64'h0, {64{1'b1}}});
      rq(AOC_OP_CAS, 4'h2, 128'h4, 128'h9, '0, AOC_ST_SC, 128'h5);
      rq(AOC_OP_CAS, 4'h2, 128'h5, 128'h9, '0, AOC_ST_SC, 128'h5);
      rq(AOC_OP_SWAP, 4'h1, '0, '0, '0, AOC_ST_SC, 128'h9);
      rq(AOC_OP_CAS, 4'h8, '0, {64'h1, 64'h2}, '0, AOC_ST_SC, '0);
      rq(AOC_OP_SWAP, 4'h2, '0, '0, '0, AOC_ST_SC, 128'h2);
      $display("test ops done");
   endtask
   task automatic t_err();
      rq(AOC_OP_FADD, 4'h1, 128'h7, '0, 4'h1, AOC_ST_UR, '0);
      ck("urd", 1'b0, ur_detected);
      eb(AOC_ERR_POISON);
      rq(AOC_OP_SWAP, 4'h1, '0, '0, '0, AOC_ST_SC, '0);
      rq(2'h3, 4'h1, '0, '0, '0, AOC_ST_UR, '0);
      ck("urd", 1'b1, ur_detected);
      eb(AOC_ERR_UR);
      rq(AOC_OP_FADD, 4'h3, '0, '0, '0, 3'h7, '0);
      eb(AOC_ERR_MAL);
      err_en <= 1'b1;
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, '0, AOC_ST_CA, '0);
      err_en <= 1'b0;
      eb(AOC_ERR_CA);
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, 4'h8, AOC_ST_CA, '0);
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, 4'h4, AOC_ST_UR, '0);
      eb(AOC_ERR_PEER);
      wr(AOC_REG_CTRL, 32'h80);
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, 4'h2, AOC_ST_UR, '0);
      ck("urd", 1'b0, ur_detected);
      rd(AOC_REG_ERR, rv, rr);
      ck("egb", 2'h3, rv[5:4]);
      wr(AOC_REG_ERR, 32'hffff_ffff);
      wr(AOC_REG_SEV, 32'h10);
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, 4'h2, AOC_ST_UR, '0);
      rd(AOC_REG_ERR, rv, rr);
      ck("fatal", 2'h1, rv[5:4]);
      wr(AOC_REG_ERR, 32'hffff_ffff);
      wr(AOC_REG_CTRL, 32'h0);
      wr(AOC_REG_WIN_HI, 32'h10);
      rq(AOC_OP_FADD, 4'h1, 128'h1, '0, '0, AOC_ST_CA, '0);
      $display("test errors done");
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ops();
      t_err();
      end_sim();
   end
endmodule
